/* ilv_ctrl.v */
// Behaviour
// - Codes zero and seven block; codes one-six give levels
// - Pending flag reads one while request outstanding
// - Writing zero clears pending; one is ignored
// - Mode bit2 enables ext input; bit1 level
// - Mode bit0 adds NMI rising edge; resets zero
// - Four write-only DMA start vectors, reset zero
//
// The AHB-Lite register port was decided locally.
`include "ilv_regs.vh"

module ilv_ctrl #(
  parameter NSRC = 8,
  parameter SW = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [NSRC-1:0] src_req,
  input wire ext_irq0,
  input wire nmi_n,
  input wire irq_ack,
  output reg irq_req,
  output reg [2:0] irq_level,
  output reg [SW-1:0] irq_src,
  output reg nmi_req,
  output reg [19:0] dma_start_vectors,
  output reg [2:0] mode_bits,
  output reg intr
);

  // Peripheral sources plus the external input as the last source
  // irq_src must be wide enough to name the external source too
  localparam NT = NSRC + 1;
  localparam EXT = NSRC;

  // Codes zero and seven both block; others map straight to level
  function [2:0] prio_level;
    input [2:0] code;
    begin
      if (code == `ILV_PRIO_OFF || code == `ILV_PRIO_OFF_TOO) begin
        prio_level = 3'h0;
      end else begin
        prio_level = code;
      end
    end
  endfunction

  function is_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  function [11:0] idx_addr;
    input [7:0] idx;
    begin
      idx_addr = {2'b00, idx, 2'b00};
    end
  endfunction

  // hsize is not decoded; every register is one aligned word
  // Address phase capture
  reg ap_wr_q;
  reg [11:0] ap_addr_q;
  wire ap_valid;
  assign ap_valid = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 12'h000;
    end else if (hready) begin
      ap_wr_q <= ap_valid & hwrite;
      ap_addr_q <= haddr[11:0];
    end
  end

  // Zero wait state slave, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Pin synchronisers; stage one feeds stage two only
  // Stage three only holds the last synced level for edge detection
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_s3_q;
  // NMI stages reset high, the idle level, so no false edge follows reset
  reg nmi_s1_q;
  reg nmi_s2_q;
  reg nmi_s3_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      nmi_s1_q <= 1'b1;
      nmi_s2_q <= 1'b1;
      nmi_s3_q <= 1'b1;
    end else begin
      ext_s1_q <= ext_irq0;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      nmi_s1_q <= nmi_n;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  wire write_mode;
  assign write_mode = ap_wr_q & is_addr(ap_addr_q, idx_addr(`ILV_IDX_INPUT_MODE));

  // Input mode bits, write only; their word reads back as zero
  // Written whole, as there is no read-modify-write path for them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_bits <= `ILV_RST_MODE;
    end else if (write_mode) begin
      mode_bits <= hwdata[2:0];
    end
  end

  wire ext_en;
  wire ext_level;
  wire nmi_rise_en;
  assign ext_en = mode_bits[`ILV_MODE_EXT_EN];
  assign ext_level = mode_bits[`ILV_MODE_EXT_LEVEL];
  assign nmi_rise_en = mode_bits[`ILV_MODE_NMI_RISE];

  // External trigger: edge or level, only while enabled
  // Level mode re-triggers every cycle, so a clear cannot win while high
  wire ext_trig;
  assign ext_trig = ext_en & (ext_level ? ext_s2_q : (ext_s2_q & ~ext_s3_q));

  // NMI always fires on the falling edge, optionally on the rising one
  wire nmi_fall;
  wire nmi_rise;
  wire nmi_trig;
  assign nmi_fall = nmi_s3_q & ~nmi_s2_q;
  assign nmi_rise = ~nmi_s3_q & nmi_s2_q;
  assign nmi_trig = nmi_fall | (nmi_rise & nmi_rise_en);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_req <= 1'b0;
    end else begin
      nmi_req <= nmi_trig;
    end
  end

  // Peripheral requests are same-clock logic; a rising edge latches
  reg [NSRC-1:0] src_prev_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev_q <= {NSRC{1'b0}};
    end else begin
      src_prev_q <= src_req;
    end
  end

  wire [NT-1:0] trig;
  assign trig = {ext_trig, src_req & ~src_prev_q};

  // Per-source priority code and pending flag
  reg [2:0] prio_q [0:NT-1];
  reg [NT-1:0] pend_q;
  wire [NT-1:0] src_wr;
  wire [NT-1:0] ack_hit;

  genvar g;
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_src
      // Word offset kept wide, then cut to the decoded span
      wire [31:0] src_off;
      assign src_off = g * 4;
      assign src_wr[g] = ap_wr_q & is_addr(ap_addr_q, `ILV_SRC_BASE + src_off[11:0]);
      assign ack_hit[g] = irq_ack & irq_req & (irq_src == g);

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          prio_q[g] <= `ILV_RST_PRIO;
        end else if (src_wr[g]) begin
          prio_q[g] <= hwdata[`ILV_PRIO_MSB:`ILV_PRIO_LSB];
        end
      end
    end
  endgenerate

  // A new trigger wins over a clear in the same cycle
  integer p;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= {NT{1'b0}};
    end else begin
      for (p = 0; p < NT; p = p + 1) begin
        if (trig[p]) begin
          pend_q[p] <= 1'b1;
        end else if (src_wr[p] && !hwdata[`ILV_PEND_BIT]) begin
          pend_q[p] <= 1'b0;
        end else if (ack_hit[p]) begin
          pend_q[p] <= 1'b0;
        end
      end
    end
  end

  // Highest level wins; on a tie the lower source number wins
  reg [2:0] best_lvl;
  reg [SW-1:0] best_src;
  reg [2:0] lvl_i;
  integer i;
  always @* begin
    best_lvl = 3'h0;
    best_src = {SW{1'b0}};
    lvl_i = 3'h0;
    for (i = 0; i < NT; i = i + 1) begin
      lvl_i = prio_level(prio_q[i]);
      if (pend_q[i] && lvl_i > best_lvl) begin
        best_lvl = lvl_i;
        best_src = i[SW-1:0];
      end
    end
  end

  // Request registered one cycle behind the pending flags
  // Ack clears whichever source irq_src shows at the ack edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= 1'b0;
      irq_level <= 3'h0;
      irq_src <= {SW{1'b0}};
    end else begin
      irq_req <= (best_lvl != 3'h0);
      irq_level <= best_lvl;
      irq_src <= best_src;
    end
  end

  // DMA start vectors, write only; each channel keeps vector bits 4..0
  // One process packs all four channels so the output has one driver
  wire [3:0] vec_wr;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_dma
      wire [31:0] dma_idx;
      assign dma_idx = `ILV_IDX_DMA_CH0 + g;
      assign vec_wr[g] = ap_wr_q & is_addr(ap_addr_q, idx_addr(dma_idx[7:0]));
    end
  endgenerate

  integer j;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_start_vectors <= {4{`ILV_RST_VEC}};
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        if (vec_wr[j]) begin
          dma_start_vectors[j*5 +: 5] <= hwdata[4:0];
        end
      end
    end
  end

  // Sticky event status, write one to clear; set wins
  // Peripheral sources share one status bit; software polls their words
  reg [`ILV_EVT_W-1:0] evt_q;
  reg [`ILV_EVT_W-1:0] evt_mask_q;
  wire [`ILV_EVT_W-1:0] evt_set;
  wire evt_clr_wr;
  wire evt_mask_wr;
  assign evt_set = {|trig[NSRC-1:0], ext_trig, nmi_trig};
  assign evt_clr_wr = ap_wr_q & is_addr(ap_addr_q, `ILV_EVT_STATUS);
  assign evt_mask_wr = ap_wr_q & is_addr(ap_addr_q, `ILV_EVT_MASK);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_q <= `ILV_RST_EVT;
      evt_mask_q <= `ILV_RST_EVT;
    end else begin
      evt_q <= evt_set | (evt_q & ~({`ILV_EVT_W{evt_clr_wr}} & hwdata[`ILV_EVT_W-1:0]));
      if (evt_mask_wr) begin
        evt_mask_q <= hwdata[`ILV_EVT_W-1:0];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      intr <= 1'b0;
    end else begin
      intr <= |(evt_q & evt_mask_q);
    end
  end

  // Read mux at the address phase; write-only words read zero
  // Limitation: a pipelined read right behind a write to the same word
  // is decoded before that write lands and returns the old value
  reg [31:0] rd_d;
  reg [31:0] rd_off;
  integer k;
  always @* begin
    rd_d = 32'h0000_0000;
    rd_off = 32'h0000_0000;
    for (k = 0; k < NT; k = k + 1) begin
      rd_off = k * 4;
      if (is_addr(haddr[11:0], `ILV_SRC_BASE + rd_off[11:0])) begin
        rd_d = {28'h000_0000, pend_q[k], prio_q[k]};
      end
    end
    if (is_addr(haddr[11:0], `ILV_EVT_STATUS)) begin
      rd_d = {29'h0000_0000, evt_q};
    end
    if (is_addr(haddr[11:0], `ILV_EVT_MASK)) begin
      rd_d = {29'h0000_0000, evt_mask_q};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= rd_d;
    end
  end

endmodule // ilv_ctrl

/* ilv_regs.vh */
`ifndef ILV_REGS_VH
`define ILV_REGS_VH

// Register indices; the byte address is four times the index
`define ILV_IDX_INPUT_MODE 8'h7B
`define ILV_IDX_DMA_CH0 8'h7C
`define ILV_IDX_DMA_CH1 8'h7D
`define ILV_IDX_DMA_CH2 8'h7E
`define ILV_IDX_DMA_CH3 8'h7F

// Per-source control words, one word per source from this base
`define ILV_SRC_BASE 12'h000
// Event status (write one to clear) and its mask
`define ILV_EVT_STATUS 12'h100
`define ILV_EVT_MASK 12'h104

// Per-source control word fields
`define ILV_PRIO_LSB 0
`define ILV_PRIO_MSB 2
`define ILV_PEND_BIT 3

// Input mode fields
`define ILV_MODE_NMI_RISE 0
`define ILV_MODE_EXT_LEVEL 1
`define ILV_MODE_EXT_EN 2

// Event status bits
`define ILV_EVT_NMI 0
`define ILV_EVT_EXT 1
`define ILV_EVT_SRC 2
`define ILV_EVT_W 3

// Reset values
`define ILV_RST_MODE 3'h0
`define ILV_RST_VEC 5'h00
`define ILV_RST_PRIO 3'h0
`define ILV_RST_EVT 3'h0

// Priority codes
`define ILV_PRIO_OFF 3'h0
`define ILV_PRIO_OFF_TOO 3'h7

`endif

/* ilv_ctrl_monitor.sv */
module ilv_ctrl_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire irq_req,
  input wire [2:0] irq_level,
  input wire nmi_req,
  input wire nmi_n,
  input wire [19:0] dma_start_vectors,
  input wire [2:0] mode_bits
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_q, rd_q;
  logic [11:0] a_q;
  logic [31:0] wd_q;
  // Tracks the data phase so each write can be tied to its data word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= 12'h000;
      wd_q <= 32'h0;
    end else begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      rd_q <= hsel & hready & htrans[1] & !hwrite;
      a_q <= haddr[11:0];
      wd_q <= hwdata;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  level_range_a: assert property (irq_req |-> irq_level inside {[3'h1:3'h6]})
    else $error("irq level out of range");
  mode_write_a: assert property (wr_q && a_q == 12'h1EC |=> mode_bits == wd_q[2:0])
    else $error("mode bits not written");
  mode_hold_a: assert property (!(wr_q && a_q == 12'h1EC) |=> $stable(mode_bits))
    else $error("mode bits changed");
  dma_first_a: assert property (wr_q && a_q == 12'h1F0 |=> dma_start_vectors[4:0] == wd_q[4:0])
    else $error("channel 0 vector wrong");
  dma_last_a: assert property (wr_q && a_q == 12'h1FC |=> dma_start_vectors[19:15] == wd_q[4:0])
    else $error("channel 3 vector wrong");
  dma_hold_a: assert property (!(wr_q && a_q[11:4] == 8'h1F) |=> $stable(dma_start_vectors))
    else $error("vectors changed");
  wo_read_a: assert property (rd_q && a_q >= 12'h1EC && a_q <= 12'h1FC |-> hrdata == 32'h0)
    else $error("write-only read nonzero");
  nmi_pulse_a: assert property (nmi_req |-> $past(nmi_n, 3) != $past(nmi_n, 4))
    else $error("nmi request without pin edge");
  nmi_edge_a: assert property (nmi_req && $past(nmi_n, 3) |-> $past(mode_bits[0]))
    else $error("nmi rising edge while disabled");
  read_ok_a: assert property (rd_q |-> hreadyout && !hresp)
    else $error("read response not okay");
  level_zero_a: assert property (!irq_req |-> irq_level == 3'h0)
    else $error("level shown without request");
endmodule // ilv_ctrl_monitor

/* ilv_cpu_model.sv */
module ilv_cpu_model (
  input wire hclk,
  input wire ack_en,
  input wire [3:0] dly,
  input wire irq_req,
  input wire [3:0] irq_src,
  output logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic [3:0] acked_q[$];
  initial irq_ack = 1'b0;
  // Backs off after an ack so a request still seen high is not taken twice
  always @(posedge hclk) begin
    irq_ack <= 1'b0;
    if (!ack_en || !irq_req) begin
      cnt <= 0;
    end else if (cnt == dly) begin
      irq_ack <= 1'b1;
      acked_q.push_back(irq_src);
      cnt <= -4;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // ilv_cpu_model

/* test_interrupt_level_and_dma_vector_ctrl.sv */
module test_interrupt_level_and_dma_vector_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic ext_irq0 = 1'b0, nmi_n = 1'b1, ack_en = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
  logic [1:0] htrans = 2'h0;
  logic [7:0] src_req = 8'h00;
  logic [3:0] dly = 4'h0;
  logic [2:0] modes[3] = '{3'h0, 3'h4, 3'h6};
  wire hreadyout, hresp, irq_req, irq_ack, nmi_req, intr;
  wire [31:0] hrdata;
  wire [2:0] irq_level, mode_bits;
  wire [3:0] irq_src;
  wire [19:0] dma_start_vectors;
  int fail_count = 0, n_tests = 0, seed = 32'h2FA889F5;
  logic [31:0] exp_q[$], got_q[$];
  always #10 hclk = ~hclk;
  ilv_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .src_req, .ext_irq0, .nmi_n, .irq_ack, .irq_req, .irq_level, .irq_src,
    .nmi_req, .dma_start_vectors, .mode_bits, .intr);
  ilv_cpu_model cpu (.hclk, .ack_en, .dly, .irq_req, .irq_src, .irq_ack);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!w) got_q.push_back(hrdata);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    if (got_q.size() > 0) begin
      chk("hrdata", exp_q.pop_front(), got_q.pop_front());
    end
  end
  initial begin
    wt(30000);
    fail_count++;
    test_done;
  end
  initial begin
    wt(2);
    hresetn <= 1'b1;
    wt(1);
    chk("dma_start_vectors", 32'h0, {12'h0, dma_start_vectors});
    chk("mode_bits", 32'h0, {29'h0, mode_bits});
    for (int c = 0; c < 8; c++) begin
      wr(12'h000, c);
      src_req <= 8'h01;
      wt(1);
      src_req <= 8'h00;
      wt(4);
      chk("irq_req", c != 0 && c != 7, irq_req);
      if (c != 0 && c != 7) chk("irq_level", c, irq_level);
      rd(12'h000, 32'h8 | c);
      wr(12'h000, 32'h8 | c);
      rd(12'h000, 32'h8 | c);
      wr(12'h000, c);
      rd(12'h000, c);
    end
    wr(12'h004, 32'h5);
    wr(12'h008, 32'h5);
    ack_en <= 1'b1;
    for (int d = 0; d < 6; d += 5) begin
      dly <= d[3:0];
      src_req <= 8'h06;
      wt(1);
      src_req <= 8'h00;
      wt(30);
      chk("acked", 32'h1, cpu.acked_q.pop_front());
      chk("acked", 32'h2, cpu.acked_q.pop_front());
      rd(12'h004, 32'h5);
    end
    ack_en <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(12'h1EC, i);
      wt(1);
      chk("mode_bits", i, mode_bits);
      rd(12'h1EC, 32'h0);
      wr(12'h1F0 | {8'h0, i[1:0], 2'h0}, v);
      wt(1);
      chk("dma_start_vectors", v[4:0], dma_start_vectors[5 * i[1:0] +: 5]);
      rd(12'h1F0 | {8'h0, i[1:0], 2'h0}, 32'h0);
    end
    foreach (modes[k]) begin
      wr(12'h1EC, modes[k]);
      wr(12'h020, 32'h3);
      ext_irq0 <= 1'b1;
      wt(6);
      rd(12'h020, {28'h0, modes[k][2], 3'h3});
      wr(12'h020, 32'h3);
      wt(6);
      rd(12'h020, {28'h0, modes[k][2] & modes[k][1], 3'h3});
      ext_irq0 <= 1'b0;
      wt(6);
      wr(12'h020, 32'h3);
    end
    for (int b = 0; b < 2; b++) begin
      wr(12'h1EC, b);
      wr(12'h104, 32'h1);
      wr(12'h100, 32'h7);
      nmi_n <= 1'b0;
      wt(8);
      chk("intr", 32'h1, intr);
      wr(12'h100, 32'h7);
      wt(2);
      chk("intr", 32'h0, intr);
      nmi_n <= 1'b1;
      wt(8);
      chk("intr", b, intr);
      rd(12'h100, b);
    end
    wr(12'h104, 32'h0);
    wt(2);
    chk("intr", 32'h0, intr);
    wr(12'h100, 32'h7);
    rd(12'h100, 32'h0);
    rd(12'hF00, 32'h0);
    wt(4);
    test_done;
  end
endmodule // test_interrupt_level_and_dma_vector_ctrl
bind ilv_ctrl ilv_ctrl_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .irq_req, .irq_level, .nmi_req, .nmi_n, .dma_start_vectors, .mode_bits);
